// *** logic/sid_decoder.sv ***
// Operation
// - servo enable on turns the drive stage on.
// - servo enable off turns the drive off, motor free.
// - alarm clear on resets the latched alarm; off does nothing.
// - alarm clear never clears undervoltage or overcurrent; only restart does.
// - ccw limit on permits ccw motion, off forbids it.
// - cw limit on permits cw motion, off forbids it.
// - limit bypass set ignores both limits, both directions allowed.
// - speed mode with internal source makes selectors pick internal speed.
// - selectors off/off 1, a 2, b 3, both 4.
// - position mode turns selector a into deviation counter clear.
// - counter clear on resets deviation counter, off holds it.
// - speed mode with external source makes selector a the zero clamp.
// - clamp on forces speed zero, off uses analog speed input.
// - encoder A, B, index repeated on differential outputs.
// - index also given on an open-collector output.
//
// Our own choices: the register offsets and the APB register port.
module sid_decoder
	import sid_pkg::*;
#(
	parameter int SETTLE_CYCLES = SID_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SID_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic irq,
	// control pins
	input wire logic servo_enable_in,
	input wire logic alarm_clear_in,
	input wire logic ccw_limit_in,
	input wire logic cw_limit_in,
	input wire logic speed_select_a,
	input wire logic speed_select_b,
	// motor encoder
	input wire logic enc_a_in,
	input wire logic enc_b_in,
	input wire logic enc_z_in,
	// encoder repeat
	output logic enc_out_a,
	output logic enc_out_a_n,
	output logic enc_out_b,
	output logic enc_out_b_n,
	output logic enc_out_index,
	output logic enc_out_index_n,
	input wire logic enc_index_open_collector_i,
	output logic enc_index_open_collector_o,
	output logic enc_index_open_collector_oe_n,
	// drive core
	input wire logic alarm_event,
	input wire logic undervoltage_fault,
	input wire logic overcurrent_fault,
	output sid_drv_t drive_cmd,
	output logic alarm_active
);

	typedef struct packed {
		sid_pin_t s1;
		sid_pin_t s2;
		sid_pin_t s3;
		sid_pin_t filt;
		sid_fsm_t fsm;
		logic [SID_CNT_W-1:0] cnt;
		logic [SID_MODE_W-1:0] mode;
		logic bypass;
		logic src;
		logic alarm;
		logic uv;
		logic oc;
		logic alarm_o;
		logic [SID_NIRQ-1:0] ist;
		logic [SID_NIRQ-1:0] ien;
		logic irq;
		sid_drv_t drv;
		logic [2:0] enc_p;
		logic [2:0] enc_n;
		logic oc_out;
		logic oc_oe_n;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sid_st_t;

	localparam sid_st_t SID_ST_RST = '{
		fsm: SID_OFF,
		mode: SID_MODE_RST,
		drv: SID_DRV_RST,
		enc_n: 3'h7,
		oc_oe_n: 1'b1,
		default: '0
	};

	sid_st_t st;
	sid_st_t nx;
	sid_pin_t pin_raw;
	logic flt;
	logic setup;
	logic wr;
	logic [SID_NIRQ-1:0] ev;
	logic [31:0] rd;

	assign pin_raw = '{
		oc_fb: enc_index_open_collector_i,
		serv_en: servo_enable_in,
		alarm_clr: alarm_clear_in,
		ccw_lim: ccw_limit_in,
		cw_lim: cw_limit_in,
		sel_a: speed_select_a,
		sel_b: speed_select_b,
		enc_a: enc_a_in,
		enc_b: enc_b_in,
		enc_z: enc_z_in
	};

	always_comb begin
		nx = st;
		ev = '0;
		rd = '0;
		// three stages; a level is taken only once stages two and three agree
		nx.s1 = pin_raw;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.filt = sid_pin_t'((st.s2 & st.s3) | (st.filt & (st.s2 | st.s3)));

		// new alarm wins over a clear arriving in the same cycle
		nx.alarm = alarm_event | (st.alarm & ~st.filt.alarm_clr);
		nx.uv = st.uv | undervoltage_fault;
		nx.oc = st.oc | overcurrent_fault;
		flt = nx.alarm | nx.uv | nx.oc;
		nx.alarm_o = flt;

		nx.cnt = '0;
		case (st.fsm)
			SID_OFF, SID_FAULT: begin
				nx.fsm = st.filt.serv_en ? SID_SETTLE : SID_OFF;
			end
			SID_SETTLE: begin
				// drive is on here; run is flagged once the command hold-off has passed
				if (!st.filt.serv_en) begin
					nx.fsm = SID_OFF;
				end else if (st.cnt == SID_CNT_W'(SETTLE_CYCLES - 1)) begin
					nx.fsm = SID_RUN;
					ev[SID_IRQ_READY] = 1'b1;
				end else begin
					nx.cnt = st.cnt + 1'b1;
				end
			end
			SID_RUN: begin
				if (!st.filt.serv_en) begin
					nx.fsm = SID_OFF;
				end
			end
			default: begin
				nx.fsm = SID_OFF;
			end
		endcase
		// any latched alarm or fault drops the drive stage
		if (flt) begin
			nx.fsm = SID_FAULT;
		end

		nx.drv.drive_en = (nx.fsm == SID_SETTLE) || (nx.fsm == SID_RUN);
		nx.drv.motor_free = ~nx.drv.drive_en;
		nx.drv.ccw_ok = st.bypass | st.filt.ccw_lim;
		nx.drv.cw_ok = st.bypass | st.filt.cw_lim;
		nx.drv.spd_int = 1'b0;
		nx.drv.spd_idx = 2'h0;
		nx.drv.zero_clamp = 1'b0;
		nx.drv.dev_clr = 1'b0;
		case (st.mode)
			SID_MODE_POS: begin
				nx.drv.dev_clr = st.filt.sel_a;
			end
			SID_MODE_SPEED: begin
				if (!st.src) begin
					nx.drv.spd_int = 1'b1;
					nx.drv.spd_idx = {st.filt.sel_b, st.filt.sel_a};
				end else begin
					nx.drv.zero_clamp = st.filt.sel_a;
				end
			end
			default: begin
			end
		endcase

		nx.enc_p = {st.filt.enc_z, st.filt.enc_b, st.filt.enc_a};
		nx.enc_n = ~nx.enc_p;
		// pulled low while the index is high, released otherwise
		nx.oc_out = 1'b0;
		nx.oc_oe_n = ~st.filt.enc_z;

		ev[SID_IRQ_ALARM] = nx.alarm & ~st.alarm;
		ev[SID_IRQ_FAULT] = (nx.uv & ~st.uv) | (nx.oc & ~st.oc);
		ev[SID_IRQ_LIMIT] = st.drv.drive_en & ((st.drv.ccw_ok & ~nx.drv.ccw_ok) | (st.drv.cw_ok & ~nx.drv.cw_ok));

		// apb: answer registered in setup, write committed at the access edge
		setup = psel & ~penable;
		wr = psel & penable & st.pready & pwrite;
		if (wr && paddr == SID_CTRL_OFS) begin
			nx.mode = pwdata[SID_CTRL_MODE_LSB +: SID_MODE_W];
			nx.bypass = pwdata[SID_CTRL_BYPASS];
			nx.src = pwdata[SID_CTRL_SRC];
		end
		if (wr && paddr == SID_IEN_OFS) begin
			nx.ien = pwdata[SID_NIRQ-1:0];
		end
		if (wr && paddr == SID_ICLR_OFS) begin
			nx.ist = st.ist & ~pwdata[SID_NIRQ-1:0];
		end
		nx.ist = nx.ist | ev;
		nx.irq = |(nx.ist & nx.ien);

		nx.pready = setup;
		nx.pslverr = 1'b0;
		case (paddr)
			SID_CTRL_OFS: begin
				rd[SID_CTRL_MODE_LSB +: SID_MODE_W] = st.mode;
				rd[SID_CTRL_BYPASS] = st.bypass;
				rd[SID_CTRL_SRC] = st.src;
			end
			SID_STAT_OFS: begin
				rd[SID_STAT_FSM_LSB +: $bits(sid_fsm_t)] = st.fsm;
				rd[SID_STAT_ALARM] = st.alarm;
				rd[SID_STAT_UV] = st.uv;
				rd[SID_STAT_OC] = st.oc;
				rd[SID_STAT_PIN_LSB +: SID_NPIN] = st.filt;
			end
			SID_IST_OFS: begin
				rd[SID_NIRQ-1:0] = st.ist;
			end
			SID_IEN_OFS: begin
				rd[SID_NIRQ-1:0] = st.ien;
			end
			SID_ICLR_OFS: begin
			end
			default: begin
				nx.pslverr = setup;
			end
		endcase
		nx.prdata = setup ? rd : '0;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			st <= SID_ST_RST;
		end else begin
			st <= nx;
		end
	end

	assign pready = st.pready;
	assign prdata = st.prdata;
	assign pslverr = st.pslverr;
	assign irq = st.irq;
	assign drive_cmd = st.drv;
	assign alarm_active = st.alarm_o;
	assign enc_out_a = st.enc_p[0];
	assign enc_out_b = st.enc_p[1];
	assign enc_out_index = st.enc_p[2];
	assign enc_out_a_n = st.enc_n[0];
	assign enc_out_b_n = st.enc_n[1];
	assign enc_out_index_n = st.enc_n[2];
	assign enc_index_open_collector_o = st.oc_out;
	assign enc_index_open_collector_oe_n = st.oc_oe_n;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	enable_on_a: assert property (
		st.filt.serv_en && !flt |=> drive_cmd.drive_en && !drive_cmd.motor_free
	) else $error("drive not enabled");

	enable_off_a: assert property (
		!st.filt.serv_en |=> !drive_cmd.drive_en && drive_cmd.motor_free
	) else $error("drive not released");

	alarm_clear_a: assert property (
		st.alarm && st.filt.alarm_clr && !alarm_event |=> !st.alarm
	) else $error("alarm not cleared");

	fault_hold_a: assert property (
		(st.uv || st.oc) |=> (st.uv || st.oc) && alarm_active ##1 alarm_active
	) else $error("hard fault released");

	ccw_block_a: assert property (
		!st.bypass && !st.filt.ccw_lim |=> !drive_cmd.ccw_ok
	) else $error("ccw not blocked");

	cw_block_a: assert property (
		!st.bypass && !st.filt.cw_lim |=> !drive_cmd.cw_ok
	) else $error("cw not blocked");

	limit_bypass_a: assert property (
		st.bypass |=> drive_cmd.ccw_ok && drive_cmd.cw_ok
	) else $error("bypass ignored");

	speed_pick_a: assert property (
		st.mode == SID_MODE_SPEED && !st.src |=> drive_cmd.spd_int
			&& drive_cmd.spd_idx[0] == $past(st.filt.sel_a) && drive_cmd.spd_idx[1] == $past(st.filt.sel_b)
	) else $error("wrong internal speed");

	dev_clear_a: assert property (
		st.mode == SID_MODE_POS |=> drive_cmd.dev_clr == $past(st.filt.sel_a) && !drive_cmd.spd_int
	) else $error("deviation clear wrong");

	zero_clamp_a: assert property (
		st.mode == SID_MODE_SPEED && st.src |=> drive_cmd.zero_clamp == $past(st.filt.sel_a) && !drive_cmd.spd_int
	) else $error("zero clamp wrong");

	enc_repeat_a: assert property (
		st.filt.enc_a ##1 st.filt.enc_a |-> enc_out_a && !enc_out_a_n
	) else $error("encoder A not repeated");

	index_oc_a: assert property (
		enc_out_index |-> !enc_index_open_collector_oe_n && !enc_index_open_collector_o
	) else $error("index open collector wrong");

	pin_filter_a: assert property (
		st.s2.sel_b != st.s3.sel_b |=> st.filt.sel_b == $past(st.filt.sel_b)
	) else $error("glitch passed filter");

	settle_time_a: assert property (
		st.fsm == SID_SETTLE && nx.fsm == SID_RUN |-> st.cnt == SID_CNT_W'(SETTLE_CYCLES - 1)
	) else $error("run entered early");

	run_cov: cover property (st.fsm == SID_SETTLE ##1 st.fsm == SID_RUN);
	clear_cov: cover property (st.alarm ##1 !st.alarm);
	speed4_cov: cover property (drive_cmd.spd_int && drive_cmd.spd_idx == 2'h3);
	irq_cov: cover property ($rose(irq));
endmodule : sid_decoder

// *** logic/sid_pkg.sv ***
package sid_pkg;
	// timing
	localparam int SID_CLK_HZ = 20_000_000;
	localparam int SID_SETTLE_MS = 50;
	localparam int SID_SETTLE_CYC = SID_SETTLE_MS * (SID_CLK_HZ / 1000);
	localparam int SID_CNT_W = 24;

	// register map, byte addresses
	localparam int SID_AW = 8;
	localparam logic [7:0] SID_CTRL_OFS = 8'h00;
	localparam logic [7:0] SID_STAT_OFS = 8'h04;
	localparam logic [7:0] SID_IST_OFS = 8'h08;
	localparam logic [7:0] SID_ICLR_OFS = 8'h0c;
	localparam logic [7:0] SID_IEN_OFS = 8'h10;

	// control fields
	localparam int SID_CTRL_MODE_LSB = 0;
	localparam int SID_MODE_W = 2;
	localparam int SID_CTRL_BYPASS = 2;
	localparam int SID_CTRL_SRC = 3;
	localparam logic [1:0] SID_MODE_POS = 2'h0;
	localparam logic [1:0] SID_MODE_SPEED = 2'h1;
	localparam logic [1:0] SID_MODE_RST = SID_MODE_POS;

	// status fields
	localparam int SID_STAT_FSM_LSB = 0;
	localparam int SID_STAT_ALARM = 4;
	localparam int SID_STAT_UV = 5;
	localparam int SID_STAT_OC = 6;
	localparam int SID_STAT_PIN_LSB = 8;

	// interrupt bits
	localparam int SID_IRQ_ALARM = 0;
	localparam int SID_IRQ_FAULT = 1;
	localparam int SID_IRQ_LIMIT = 2;
	localparam int SID_IRQ_READY = 3;
	localparam int SID_NIRQ = 4;

	typedef enum logic [3:0] {
		SID_OFF = 4'h1,
		SID_SETTLE = 4'h2,
		SID_RUN = 4'h4,
		SID_FAULT = 4'h8
	} sid_fsm_t;

	typedef struct packed {
		logic oc_fb;
		logic serv_en;
		logic alarm_clr;
		logic ccw_lim;
		logic cw_lim;
		logic sel_a;
		logic sel_b;
		logic enc_a;
		logic enc_b;
		logic enc_z;
	} sid_pin_t;

	localparam int SID_NPIN = $bits(sid_pin_t);

	typedef struct packed {
		logic drive_en;
		logic motor_free;
		logic ccw_ok;
		logic cw_ok;
		logic spd_int;
		logic [1:0] spd_idx;
		logic zero_clamp;
		logic dev_clr;
	} sid_drv_t;

	localparam sid_drv_t SID_DRV_RST = '{motor_free: 1'b1, default: '0};
endpackage : sid_pkg

// *** test/sid_ctl_model.sv ***
module sid_ctl_model #(
	parameter int SETTLE = 20
) (
	// clock
	input wire logic clk_sys,
	// bench commands
	input wire logic [8:0] cmd,
	// control pins
	output logic servo_enable_in,
	output logic alarm_clear_in,
	output logic ccw_limit_in,
	output logic cw_limit_in,
	output logic speed_select_a,
	output logic speed_select_b,
	// motor encoder
	output logic enc_a_in,
	output logic enc_b_in,
	output logic enc_z_in
);
	timeunit 1ns;
	timeprecision 1ns;
	int wait_cnt = 0;
	initial {servo_enable_in, alarm_clear_in, ccw_limit_in, cw_limit_in} = '0;
	initial {speed_select_a, speed_select_b, enc_a_in, enc_b_in, enc_z_in} = '0;
	always @(posedge clk_sys) begin
		servo_enable_in <= cmd[0];
		wait_cnt <= cmd[0] ? wait_cnt + 1 : 0;
		// control pin commands held off until the enable has settled; encoder bits pass every cycle
		if (servo_enable_in && wait_cnt >= SETTLE) begin
			{speed_select_b, speed_select_a, cw_limit_in, ccw_limit_in, alarm_clear_in} <= cmd[5:1];
		end else begin
			{speed_select_b, speed_select_a, cw_limit_in, ccw_limit_in, alarm_clear_in} <= '0;
		end
		{enc_z_in, enc_b_in, enc_a_in} <= cmd[8:6];
	end
endmodule : sid_ctl_model

// *** test/sid_decoder_test.sv ***
module sid_decoder_test;
	import sid_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 8;
	logic clk_sys = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, slverr;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, q, prdata;
	logic [8:0] cmd = '0;
	logic alarm_event = 0, undervoltage_fault = 0, overcurrent_fault = 0;
	logic pready, pslverr, irq, alarm_active, enc_index_open_collector_i;
	logic enc_out_a, enc_out_a_n, enc_out_b, enc_out_b_n, enc_out_index, enc_out_index_n;
	logic enc_index_open_collector_o, enc_index_open_collector_oe_n;
	logic servo_enable_in, alarm_clear_in, ccw_limit_in, cw_limit_in, speed_select_a, speed_select_b;
	logic enc_a_in, enc_b_in, enc_z_in;
	sid_drv_t drive_cmd;
	int miscompares = 0, n_tests = 0, cycles = 0;
	// pull-up on the open-collector line
	assign enc_index_open_collector_i = enc_index_open_collector_oe_n ? 1'b1 : enc_index_open_collector_o;
	always #25 clk_sys = ~clk_sys;
	sid_decoder #(.SETTLE_CYCLES(20)) u_sid_decoder (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .irq, .servo_enable_in, .alarm_clear_in, .ccw_limit_in,
		.cw_limit_in, .speed_select_a, .speed_select_b, .enc_a_in, .enc_b_in, .enc_z_in, .enc_out_a,
		.enc_out_a_n, .enc_out_b, .enc_out_b_n, .enc_out_index, .enc_out_index_n, .enc_index_open_collector_i,
		.enc_index_open_collector_o, .enc_index_open_collector_oe_n, .alarm_event, .undervoltage_fault,
		.overcurrent_fault, .drive_cmd, .alarm_active);
	sid_ctl_model #(.SETTLE(20)) u_sid_ctl_model (.clk_sys, .cmd, .servo_enable_in, .alarm_clear_in,
		.ccw_limit_in, .cw_limit_in, .speed_select_a, .speed_select_b, .enc_a_in, .enc_b_in, .enc_z_in);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// only the cycle ceiling ends a wait for the slave
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task summarize;
		$display("compares %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : summarize
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		tick(5);
		reset_n <= 1'b1;
		tick(1);
		chk(drive_cmd.drive_en, 0);
		chk(drive_cmd.motor_free, 1);
		apb(0, SID_CTRL_OFS, 0);
		chk(q, 0);
		apb(0, 8'h20, 0);
		chk(slverr, 1);
		cmd <= 9'h001;
		tick(W);
		chk(drive_cmd.drive_en, 1);
		chk(drive_cmd.motor_free, 0);
		tick(25);
		apb(0, SID_STAT_OFS, 0);
		chk(q[3:0], SID_RUN);
		apb(0, SID_IST_OFS, 0);
		chk(q[SID_IRQ_READY], 1);
		// raise, mask, unmask, clear
		apb(1, SID_IEN_OFS, 32'h8);
		tick(2);
		chk(irq, 1);
		apb(1, SID_IEN_OFS, 0);
		tick(2);
		chk(irq, 0);
		apb(1, SID_IEN_OFS, 32'h8);
		apb(1, SID_ICLR_OFS, 32'h8);
		tick(2);
		chk(irq, 0);
		cmd <= 9'h005;
		tick(W);
		chk({drive_cmd.ccw_ok, drive_cmd.cw_ok}, 2'b10);
		cmd <= 9'h009;
		tick(W);
		chk({drive_cmd.ccw_ok, drive_cmd.cw_ok}, 2'b01);
		apb(1, SID_CTRL_OFS, 32'h4);
		cmd <= 9'h001;
		tick(W);
		chk({drive_cmd.ccw_ok, drive_cmd.cw_ok}, 2'b11);
		apb(1, SID_CTRL_OFS, 32'h1);
		for (int i = 0; i < 4; i++) begin
			cmd <= {3'b000, i[1], i[0], 4'h1};
			tick(W);
			chk(drive_cmd.spd_int, 1);
			chk(drive_cmd.spd_idx, i[1:0]);
		end
		apb(1, SID_CTRL_OFS, 0);
		cmd <= 9'h011;
		tick(W);
		chk(drive_cmd.spd_int, 0);
		chk(drive_cmd.dev_clr, 1);
		cmd <= 9'h001;
		tick(W);
		chk(drive_cmd.dev_clr, 0);
		apb(1, SID_CTRL_OFS, 32'h9);
		cmd <= 9'h011;
		tick(W);
		chk(drive_cmd.zero_clamp, 1);
		cmd <= 9'h001;
		tick(W);
		chk(drive_cmd.zero_clamp, 0);
		// a mode with no selector function leaves every selector decode off
		apb(1, SID_CTRL_OFS, 32'h2);
		cmd <= 9'h011;
		tick(W);
		chk({drive_cmd.spd_int, drive_cmd.dev_clr, drive_cmd.zero_clamp}, 3'b000);
		cmd <= 9'h141;
		tick(W);
		chk({enc_out_a, enc_out_a_n, enc_out_b, enc_out_b_n, enc_out_index, enc_out_index_n}, 6'h26);
		chk({enc_index_open_collector_o, enc_index_open_collector_i}, 2'b00);
		cmd <= 9'h081;
		tick(W);
		chk({enc_out_a, enc_out_a_n, enc_out_b, enc_out_b_n, enc_out_index, enc_out_index_n}, 6'h19);
		chk(enc_index_open_collector_oe_n, 1);
		alarm_event <= 1'b1;
		tick(1);
		alarm_event <= 1'b0;
		tick(W);
		chk({alarm_active, drive_cmd.drive_en}, 2'b10);
		cmd <= 9'h003;
		tick(W);
		chk(alarm_active, 0);
		cmd <= 9'h001;
		tick(W);
		chk(drive_cmd.drive_en, 1);
		// new alarm and lost permit both left their sticky bits
		apb(0, SID_IST_OFS, 0);
		chk(q[2:0], 3'h5);
		// each supply fault needs its own restart
		for (int f = 0; f < 2; f++) begin
			reset_n <= 1'b0;
			cmd <= 9'h000;
			tick(2);
			reset_n <= 1'b1;
			cmd <= 9'h001;
			tick(30);
			{overcurrent_fault, undervoltage_fault} <= f ? 2'b10 : 2'b01;
			tick(1);
			{overcurrent_fault, undervoltage_fault} <= 2'b00;
			cmd <= 9'h003;
			tick(W);
			chk({alarm_active, drive_cmd.drive_en}, 2'b10);
			apb(0, SID_STAT_OFS, 0);
			chk(q[SID_STAT_OC:SID_STAT_UV], f ? 2'b10 : 2'b01);
		end
		summarize();
	end
endmodule : sid_decoder_test
